// [logic/pfp_params.svh]
// Constants for the predriver fault protection block.
// Assumes a 40 MHz device clock; included by the package and the design modules.
`ifndef PFP_PARAMS_SVH
`define PFP_PARAMS_SVH
`define PFP_CLK_MHZ 40
`define PFP_OC_FILT_NS 2500
`define PFP_SAT_FILT_NS 10000
`define PFP_OC_FILT_CYC ((`PFP_OC_FILT_NS * `PFP_CLK_MHZ + 999) / 1000)
`define PFP_SAT_FILT_CYC ((`PFP_SAT_FILT_NS * `PFP_CLK_MHZ + 999) / 1000)
`define PFP_FILT_W 9
`define PFP_REP_W 5
`define PFP_BIT_OC 0
`define PFP_BIT_OL 1
`define PFP_BIT_STB 2
`define PFP_BIT_STG 3
`define PFP_BIT_OV 4
`define PFP_REP_RST 5'h00
`endif

// [logic/pfp_pkg.sv]
// Types shared by the predriver fault protection design.
// Assumes pfp_params.svh is on the include path.
`include "pfp_params.svh"
package pfp_pkg;
   typedef logic [`PFP_REP_W-1:0] pfp_report_t;
   typedef logic [`PFP_FILT_W-1:0] pfp_count_t;
   typedef enum logic [1:0] {PFP_IDLE, PFP_RUN} pfp_cycle_t;
endpackage : pfp_pkg

// [logic/pfp_filter.sv]
// Qualification filter: a comparator result must persist for a set count.
// Assumes the input is already synchronised to clk.
`include "pfp_params.svh"
module pfp_filter
   import pfp_pkg::*;
#(
   parameter pfp_count_t LIMIT = pfp_count_t'(1)
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic raw,
   output logic qual
);
   pfp_count_t count;
   pfp_count_t next_count;
   logic next_qual;

   // Count while the input stands; any drop restarts the count.
   always_comb
   begin
      next_count = count;
      next_qual = 1'b0;
      if (!raw)
      begin
         next_count = '0;
      end
      else if (count < LIMIT)
      begin
         next_count = count + pfp_count_t'(1);
      end
      if (raw && (count >= LIMIT - pfp_count_t'(1)))
      begin
         next_qual = 1'b1;
      end
   end

   // Registers only.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         count <= '0;
         qual <= 1'b0;
      end
      else
      begin
         count <= next_count;
         qual <= next_qual;
      end
   end

   // Qualification only follows a cycle in which the input stood.
   filt_hold_a: assert property (@(posedge clk) disable iff (srst)
      qual |-> $past(raw))
      else $error("Filter qualified without a standing input.");
endmodule : pfp_filter

// [logic/pfp_fault_ctrl.sv]
// Fault detection, protection latch and fault report word for a predriver.
// Assumes comparator, control and chip select inputs are asynchronous pins.
`include "pfp_params.svh"
module pfp_fault_ctrl
(
   input wire logic clk,
   input wire logic srst,
   input wire logic cycle_control_in,
   input wire logic drive_enable_in,
   input wire logic chip_select_n,
   input wire logic overcurrent_ref_in,
   input wire logic hs_sat_in,
   input wire logic fw_sat_in,
   input wire logic loop_state_in,
   input wire logic hs_drive_on,
   input wire logic fw_drive_on,
   input wire logic overvoltage_in,
   input wire logic hs_thresh_sel_in,
   input wire logic fw_thresh_sel_in,
   output logic drive_off,
   output logic fault_n_o,
   output logic fault_n_oe,
   output pfp_pkg::pfp_report_t shift_word,
   output logic hs_thresh_high,
   output logic fw_thresh_high
);
   import pfp_pkg::*;

   localparam pfp_count_t OC_LIM = pfp_count_t'(`PFP_OC_FILT_CYC);
   localparam pfp_count_t SAT_LIM = pfp_count_t'(`PFP_SAT_FILT_CYC);

   // Two-stage synchronisers; stage one is read by stage two only.
   localparam int NSYNC = 9;
   logic [NSYNC-1:0] sync1;
   logic [NSYNC-1:0] sync2;
   logic [NSYNC-1:0] pins;
   assign pins = {fw_thresh_sel_in, hs_thresh_sel_in, overvoltage_in, loop_state_in,
                  fw_sat_in, hs_sat_in, overcurrent_ref_in, chip_select_n, cycle_control_in};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++)
      begin : g_sync
         always_ff @(posedge clk)
         begin
            if (srst)
            begin
               sync1[gi] <= (gi == 1);
               sync2[gi] <= (gi == 1);
            end
            else
            begin
               sync1[gi] <= pins[gi];
               sync2[gi] <= sync1[gi];
            end
         end
      end
   endgenerate

   logic ena_s1;
   logic ena_s;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ena_s1 <= 1'b0;
         ena_s <= 1'b0;
      end
      else
      begin
         ena_s1 <= drive_enable_in;
         ena_s <= ena_s1;
      end
   end

   logic ctl_s;
   logic cs_s;
   logic loop_s;
   assign ctl_s = sync2[0];
   assign cs_s = sync2[1];
   assign loop_s = sync2[5];

   // The qualified comparators; saturation only counts while its drive is on.
   logic in_cycle;
   logic oc_q;
   logic hs_q;
   logic fw_q;
   assign in_cycle = ctl_s & ena_s;

   pfp_filter #(.LIMIT(OC_LIM)) u_oc_filt (
      .clk(clk),
      .srst(srst),
      .raw(sync2[2]),
      .qual(oc_q)
   );
   pfp_filter #(.LIMIT(SAT_LIM)) u_hs_filt (
      .clk(clk),
      .srst(srst),
      .raw(sync2[3] & in_cycle & hs_drive_on),
      .qual(hs_q)
   );
   pfp_filter #(.LIMIT(SAT_LIM)) u_fw_filt (
      .clk(clk),
      .srst(srst),
      .raw(sync2[4] & in_cycle & fw_drive_on),
      .qual(fw_q)
   );

   // Cycle tracking, protection latch and report state.
   pfp_cycle_t state;
   pfp_cycle_t next_state;
   logic loop_prev;
   logic saw_change;
   logic next_saw_change;
   logic ol_pending;
   logic next_ol_pending;
   logic cs_prev;
   logic next_drive_off;
   logic next_fault_n_oe;
   pfp_report_t report;
   pfp_report_t next_report;
   pfp_report_t next_shift_word;
   logic cs_rise;
   logic cycle_start;
   logic cycle_end;
   logic prio_set;

   assign cs_rise = cs_s & ~cs_prev;
   assign cycle_start = (state == PFP_IDLE) && in_cycle;
   assign cycle_end = (state == PFP_RUN) && !in_cycle;
   assign prio_set = |{report[`PFP_BIT_OC], report[`PFP_BIT_STB], report[`PFP_BIT_STG]};

   // Next-state logic. A select rise clears the report, but a fault seen in
   // the same cycle is still recorded so no event is lost.
   always_comb
   begin
      next_state = state;
      next_drive_off = drive_off;
      next_saw_change = saw_change;
      next_ol_pending = ol_pending;
      next_report = report;
      next_fault_n_oe = fault_n_oe;
      next_shift_word = shift_word;
      if (cs_rise) // Cleared first, so an open load found at the same edge survives.
      begin
         next_report = `PFP_REP_RST;
         next_fault_n_oe = 1'b0;
         next_ol_pending = 1'b0;
      end
      unique case (state)
         PFP_IDLE:
         begin
            if (in_cycle)
            begin
               next_state = PFP_RUN;
               next_drive_off = 1'b0;
               next_saw_change = 1'b0;
            end
         end
         PFP_RUN:
         begin
            if (loop_s != loop_prev)
            begin
               next_saw_change = 1'b1;
            end
            if (!in_cycle)
            begin
               next_state = PFP_IDLE;
               next_ol_pending = ~saw_change;
            end
         end
      endcase
      if ((oc_q && in_cycle) || hs_q || fw_q)
      begin
         next_drive_off = 1'b1;
      end
      if (oc_q || hs_q || fw_q)
      begin
         next_fault_n_oe = 1'b1;
      end
      if (!(prio_set && !cs_rise))
      begin
         // First priority fault wins; overcurrent ranks first on a tie.
         if (oc_q)
         begin
            next_report[`PFP_BIT_OC] = 1'b1;
         end
         else if (fw_q)
         begin
            next_report[`PFP_BIT_STB] = 1'b1;
         end
         else if (hs_q)
         begin
            next_report[`PFP_BIT_STG] = 1'b1;
         end
      end
      if (sync2[6])
      begin
         next_report[`PFP_BIT_OV] = 1'b1;
      end
      // Open load only shows when nothing of priority is held.
      next_report[`PFP_BIT_OL] = next_ol_pending & ~(|{next_report[`PFP_BIT_OC],
                                 next_report[`PFP_BIT_STB], next_report[`PFP_BIT_STG]});
      if (cs_s)
      begin
         next_shift_word = next_report;
      end
   end

   // Registers only.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state <= PFP_IDLE;
         loop_prev <= 1'b0;
         saw_change <= 1'b0;
         ol_pending <= 1'b0;
         cs_prev <= 1'b1;
         drive_off <= 1'b0;
         fault_n_oe <= 1'b0;
         report <= `PFP_REP_RST;
         shift_word <= `PFP_REP_RST;
         hs_thresh_high <= 1'b0;
         fw_thresh_high <= 1'b0;
         fault_n_o <= 1'b0;
      end
      else
      begin
         state <= next_state;
         loop_prev <= loop_s;
         saw_change <= next_saw_change;
         ol_pending <= next_ol_pending;
         cs_prev <= cs_s;
         drive_off <= next_drive_off;
         fault_n_oe <= next_fault_n_oe;
         report <= next_report;
         shift_word <= next_shift_word;
         hs_thresh_high <= sync2[7];
         fw_thresh_high <= sync2[8];
         fault_n_o <= 1'b0;
      end
   end

   // Assertions.
   sequence cs_edge_s;
      cs_s && !cs_prev;
   endsequence
   oc_latch_a: assert property (@(posedge clk) disable iff (srst)
      (oc_q && in_cycle) |=> drive_off)
      else $error("Overcurrent in cycle did not latch drives off.");
   oc_flag_a: assert property (@(posedge clk) disable iff (srst)
      oc_q |=> fault_n_oe)
      else $error("Overcurrent did not assert the fault flag.");
   sat_latch_a: assert property (@(posedge clk) disable iff (srst)
      (hs_q || fw_q) |=> (drive_off && fault_n_oe))
      else $error("Saturation did not shut drives and flag.");
   prot_hold_a: assert property (@(posedge clk) disable iff (srst)
      (drive_off && !cycle_start) |=> drive_off)
      else $error("Protection cleared without a new cycle.");
   cs_clear_a: assert property (@(posedge clk) disable iff (srst)
      (cs_edge_s ##0 !(oc_q || hs_q || fw_q)) |=> !fault_n_oe)
      else $error("Select rise did not clear the fault flag.");
   ol_noflag_a: assert property (@(posedge clk) disable iff (srst)
      (!fault_n_oe && !(oc_q || hs_q || fw_q)) |=> !fault_n_oe)
      else $error("Fault flag set without a priority fault.");
   one_prio_a: assert property (@(posedge clk) disable iff (srst)
      $onehot0({report[`PFP_BIT_OC], report[`PFP_BIT_STB], report[`PFP_BIT_STG]}))
      else $error("More than one priority bit recorded.");
   load_block_a: assert property (@(posedge clk) disable iff (srst)
      (!cs_s ##1 !cs_s) |-> $stable(shift_word))
      else $error("Report word changed while select low.");
   ol_end_a: assert property (@(posedge clk) disable iff (srst)
      ($rose(ol_pending)) |-> $past(cycle_end))
      else $error("Open load raised outside a cycle end.");
   ol_clear_a: assert property (@(posedge clk) disable iff (srst)
      (cs_edge_s ##0 !cycle_end) |=> !ol_pending)
      else $error("Open load survived a select rise.");
endmodule : pfp_fault_ctrl

// [sim/pfp_host_model.sv]
// Host model: drives the cycle control, enable and chip select pins.
// Assumes the bench calls its tasks; pins change on the falling clock edge.
module pfp_host_model
(
   input wire logic clk,
   output logic cycle_control_in,
   output logic drive_enable_in,
   output logic chip_select_n
);
   timeunit 1ns;
   timeprecision 100ps;

   // Pins start idle: no cycle running and the device deselected.
   initial
   begin
      cycle_control_in = 1'h0;
      drive_enable_in = 1'h1;
      chip_select_n = 1'h1;
   end

   // A control cycle runs while both pins are high; a low then high restarts it.
   task automatic set_cycle(input logic ctl, input logic ena);
      @(negedge clk);
      cycle_control_in = ctl;
      drive_enable_in = ena;
   endtask : set_cycle

   // The host always ends a read by raising select, which acknowledges faults.
   task automatic set_select(input logic cs_n);
      @(negedge clk);
      chip_select_n = cs_n;
   endtask : set_select
endmodule : pfp_host_model

// [sim/pfp_fault_ctrl_test.sv]
// Self-checking testbench for the predriver fault protection block.
// Assumes the host model drives control, enable and select; the bench drives the rest.
module pfp_fault_ctrl_test;
   timeunit 1ns;
   timeprecision 100ps;
   import pfp_pkg::*;

   logic clk = 1'h0;
   logic srst = 1'h1;
   logic overcurrent_ref_in = 1'h0;
   logic hs_sat_in = 1'h0;
   logic fw_sat_in = 1'h0;
   logic loop_state_in = 1'h0;
   logic hs_drive_on = 1'h0;
   logic fw_drive_on = 1'h0;
   logic overvoltage_in = 1'h0;
   logic hs_thresh_sel_in = 1'h1;
   logic fw_thresh_sel_in = 1'h0;
   wire logic cycle_control_in;
   wire logic drive_enable_in;
   wire logic chip_select_n;
   wire logic drive_off;
   wire logic fault_n_o;
   wire logic fault_n_oe;
   wire logic hs_thresh_high;
   wire logic fw_thresh_high;
   pfp_report_t shift_word;
   int failures = 0;
   int checks = 0;

   // The 40 MHz device clock.
   always #12.5 clk = ~clk;

   pfp_host_model u_host (
      .clk(clk),
      .cycle_control_in(cycle_control_in),
      .drive_enable_in(drive_enable_in),
      .chip_select_n(chip_select_n)
   );

   pfp_fault_ctrl u_dut (
      .clk(clk),
      .srst(srst),
      .cycle_control_in(cycle_control_in),
      .drive_enable_in(drive_enable_in),
      .chip_select_n(chip_select_n),
      .overcurrent_ref_in(overcurrent_ref_in),
      .hs_sat_in(hs_sat_in),
      .fw_sat_in(fw_sat_in),
      .loop_state_in(loop_state_in),
      .hs_drive_on(hs_drive_on),
      .fw_drive_on(fw_drive_on),
      .overvoltage_in(overvoltage_in),
      .hs_thresh_sel_in(hs_thresh_sel_in),
      .fw_thresh_sel_in(fw_thresh_sel_in),
      .drive_off(drive_off),
      .fault_n_o(fault_n_o),
      .fault_n_oe(fault_n_oe),
      .shift_word(shift_word),
      .hs_thresh_high(hs_thresh_high),
      .fw_thresh_high(fw_thresh_high)
   );

   // Compares one value; case inequality keeps an unknown from passing.
   task automatic check(input logic [4:0] seen, input logic [4:0] exp);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic expect3(input logic d, input logic f, input logic [4:0] w);
      check(drive_off, d);
      check(fault_n_oe, f);
      check(shift_word, w);
   endtask : expect3

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_clk

   // Inputs pass two synchronisers, so a pulse is held in whole cycles.
   task automatic hold(ref logic sig, input int n);
      sig = 1'h1;
      wait_clk(n);
      sig = 1'h0;
   endtask : hold

   task automatic toggle_loop();
      wait_clk(4);
      loop_state_in = ~loop_state_in;
      wait_clk(4);
   endtask : toggle_loop

   // A short read frame; the settle time covers the select synchroniser.
   task automatic acknowledge();
      u_host.set_select(1'h0);
      wait_clk(4);
      u_host.set_select(1'h1);
      wait_clk(6);
   endtask : acknowledge

   task automatic summarize();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize

   // Watchdog: the tests take about 3000 cycles, so 8000 cycles means a hang.
   initial
   begin
      #200000;
      failures++;
      summarize();
   end

   // Main sequence of scenarios.
   initial
   begin
      wait_clk(8);
      srst = 1'h0;
      wait_clk(4);
      expect3(1'h0, 1'h0, 5'h00);
      check(fault_n_o, 1'h0);
      check(hs_thresh_high, 1'h1);
      check(fw_thresh_high, 1'h0);
      hs_thresh_sel_in = 1'h0;
      fw_thresh_sel_in = 1'h1;
      wait_clk(4);
      check(hs_thresh_high, 1'h0);
      check(fw_thresh_high, 1'h1);
      // A glitch shorter than the filter leaves no trace.
      hold(overcurrent_ref_in, 90);
      wait_clk(10);
      expect3(1'h0, 1'h0, 5'h00);
      // Overcurrent outside a cycle flags and reports but leaves the drives alone.
      hold(overcurrent_ref_in, 110);
      wait_clk(6);
      expect3(1'h0, 1'h1, 5'h01);
      acknowledge();
      expect3(1'h0, 1'h0, 5'h00);
      // While selected the word is frozen, yet the flag still rises.
      u_host.set_select(1'h0);
      hold(overcurrent_ref_in, 110);
      wait_clk(6);
      check(shift_word, 5'h00);
      check(fault_n_oe, 1'h1);
      u_host.set_select(1'h1);
      wait_clk(6);
      check(fault_n_oe, 1'h0);
      // In a cycle overcurrent latches off; a later short and an open load stay hidden.
      u_host.set_cycle(1'h1, 1'h1);
      wait_clk(6);
      hold(overcurrent_ref_in, 110);
      wait_clk(6);
      expect3(1'h1, 1'h1, 5'h01);
      hs_drive_on = 1'h1;
      hold(hs_sat_in, 420);
      hs_drive_on = 1'h0;
      wait_clk(6);
      check(shift_word, 5'h01);
      u_host.set_cycle(1'h1, 1'h0);
      wait_clk(6);
      expect3(1'h1, 1'h1, 5'h01);
      acknowledge();
      check(drive_off, 1'h1);
      u_host.set_cycle(1'h1, 1'h1);
      wait_clk(6);
      check(drive_off, 1'h0);
      // Saturation counts only while its drive is on and past its own filter.
      toggle_loop();
      hold(hs_sat_in, 420);
      wait_clk(4);
      hs_drive_on = 1'h1;
      hold(hs_sat_in, 300);
      wait_clk(6);
      expect3(1'h0, 1'h0, 5'h00);
      hold(hs_sat_in, 420);
      hs_drive_on = 1'h0;
      wait_clk(6);
      expect3(1'h1, 1'h1, 5'h08);
      u_host.set_cycle(1'h0, 1'h1);
      acknowledge();
      u_host.set_cycle(1'h1, 1'h1);
      toggle_loop();
      fw_drive_on = 1'h1;
      hold(fw_sat_in, 420);
      fw_drive_on = 1'h0;
      wait_clk(6);
      expect3(1'h1, 1'h1, 5'h04);
      u_host.set_cycle(1'h0, 1'h1);
      acknowledge();
      // A cycle with no loop change reports open load once it ends, without the flag.
      u_host.set_cycle(1'h1, 1'h1);
      wait_clk(20);
      check(shift_word, 5'h00);
      u_host.set_cycle(1'h0, 1'h1);
      wait_clk(6);
      expect3(1'h0, 1'h0, 5'h02);
      acknowledge();
      check(shift_word, 5'h00);
      // Overvoltage only sets its report bit.
      hold(overvoltage_in, 20);
      wait_clk(6);
      expect3(1'h0, 1'h0, 5'h10);
      acknowledge();
      check(shift_word, 5'h00);
      summarize();
   end
endmodule : pfp_fault_ctrl_test
